//--- design/tmr_cfg.svh
// Purpose: offsets, field positions and reset values of the timer block
// Assumes: byte addresses on a 32-bit bus, one register per word
// Notes: definitions only
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
// register byte addresses
`define OFS_TIMER_SC 8'h00
`define OFS_COUNT_HI 8'h04
`define OFS_COUNT_LO 8'h08
`define OFS_MOD_HI 8'h0C
`define OFS_MOD_LO 8'h10
`define OFS_CHAN_SC 8'h14
`define OFS_CHAN_VAL 8'h18
// timer status/control fields
`define SC_OVF_BIT 7
`define SC_CPWM_BIT 5
`define SC_CLKS_HI 4
`define SC_CLKS_LO 3
`define SC_PS_HI 2
// channel status/control fields
`define CSC_FLAG_BIT 7
`define CSC_IE_BIT 6
`define CSC_MSU_BIT 5
`define CSC_MSL_BIT 4
`define CSC_ELU_BIT 3
`define CSC_ELL_BIT 2
// reset and count constants
`define MOD_RESET 16'h0000
`define CNT_FULL 16'hFFFF
`define CLKS_OFF 2'h0
`endif

//--- design/tmr_pkg.sv
// Purpose: shared types of the timer block
// Assumes: nothing
// Notes: constants live in tmr_cfg.svh
package tmr_pkg;
  // coherency latch of the two counter byte reads
  typedef enum logic [1:0] {CL_IDLE, CL_HI_READ, CL_LO_READ} cnt_latch_e;
  // modulo byte write buffer state
  typedef enum logic [1:0] {MW_IDLE, MW_HI_DONE, MW_LO_DONE} mod_latch_e;
  // decoded register
  typedef enum logic [2:0] {
    R_SC, R_CNTH, R_CNTL, R_MODH, R_MODL, R_CSC, R_CVAL, R_NONE
  } reg_e;
endpackage : tmr_pkg

//--- design/flag_if.sv
// Purpose: carries one sticky event flag and its clear sequence
// Assumes: single clock domain
// Notes: owner keeps the flag, user drives events and bus accesses
`timescale 1ns/1ns
`default_nettype none
interface flag_if;
  logic set_evt;
  logic rd_arm;
  logic wr_zero;
  logic flag;
  modport owner (input set_evt, input rd_arm, input wr_zero, output flag);
  modport user (output set_evt, output rd_arm, output wr_zero, input flag);
endinterface : flag_if
`default_nettype wire

//--- design/event_flag.sv
// Purpose: sticky flag with read-then-write-zero clear
// Assumes: rd_arm is a read of the flag register, wr_zero a write of 0
// Notes: an event in the clear sequence restarts it
`timescale 1ns/1ns
`default_nettype none
module event_flag (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // flag carrier
  flag_if.owner f
);
  logic flag_r, flag_nxt;
  logic armed_r, armed_nxt;

  // ----------------------------------------------------------------
  // clear sequence
  // ----------------------------------------------------------------
  // the set wins so an event is never lost to a late clear
  always_comb begin
    flag_nxt = flag_r;
    armed_nxt = armed_r;
    if (f.set_evt) begin
      flag_nxt = 1'b1;
      armed_nxt = 1'b0;
    end else if (f.wr_zero && armed_r) begin
      flag_nxt = 1'b0;
      armed_nxt = 1'b0;
    end else if (f.rd_arm && flag_r) begin
      armed_nxt = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      armed_r <= armed_nxt;
    end
  end

  assign f.flag = flag_r;
endmodule : event_flag
`default_nettype wire

//--- design/pin_edge.sv
// Purpose: synchronise the channel pin and report its edges
// Assumes: pin is asynchronous to hclk
// Notes: edges are one-cycle pulses, two edges after the pin moves
`timescale 1ns/1ns
`default_nettype none
module pin_edge (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pin and edges
  input wire logic pin_in,
  output logic rise,
  output logic fall
);
  logic s1_r, s2_r, s3_r;

  // two-flop synchroniser, then a history flop for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
endmodule : pin_edge
`default_nettype wire

//--- design/tmr_ctrl.sv
// Purpose: timer counter, modulo and one channel behind an AHB-Lite slave
// Assumes: count_tick is the prescaled tick on hclk; zero wait states
// Notes: prescaler and clock-source synchronisation sit outside
// Functional notes
// - debug halt freezes the counter so reads return the frozen count
// - debug halt freezes the counter read latch against byte reads
// - in debug, writes to status/control or count reset read latch
// - counter at modulo restarts at zero next tick and sets overflow
// - one modulo byte written suppresses overflow until the other
// - reset loads modulo zero, so the counter runs full range
// - modulo writes buffered; with clock off update on second byte
// - with clock on, update on step modulo-1 to modulo, or FFFE-FFFF
// - any status/control write resets the modulo write latch
// - in debug modulo latch frozen, writes go straight to modulo
// - channel flag set on capture edge or on counter match; with edge/level 00 the code sets no flag in any mode
// - PWM at 0% or 100% duty never sets the channel flag
// - channel interrupt request is flag and enable
// - flag clears by read while set then write zero; event restarts
// - interrupt enable bit 6 read/write; reset clears enable, flag
// - edge/level 00 releases the pin whatever the mode bits
// - mode 00: capture rising, falling or both edges
// - mode 01: output compare toggles, clears or sets on match
// - upper mode bit: edge-aligned PWM high-true or low-true
// - center-aligned: 10 clears on up match, X1 sets on up match
// - clock source 00 leaves the counter stopped
// - center-aligned select runs the counter up/down
`timescale 1ns/1ns
`default_nettype none
`include "tmr_cfg.svh"
module tmr_ctrl
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // rest of the timer unit
  input wire logic count_tick,
  input wire logic debug_halt_active,
  output logic [1:0] clock_source_select,
  output logic [2:0] prescale_select,
  output logic center_aligned_select,
  output logic [15:0] count_value,
  output logic overflow_flag,
  // channel pin and request
  input wire logic chan_pin_in,
  output logic chan_pin_out,
  output logic chan_pin_oe,
  output logic chan_irq
);
  // bus phase state
  logic wr_r, wr_nxt;
  reg_e sel_r, sel_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // timer control
  logic cpwm_r, cpwm_nxt;
  logic [1:0] clks_r, clks_nxt;
  logic [2:0] ps_r, ps_nxt;
  // counter and modulo
  logic [15:0] cnt_r, cnt_nxt, cbuf_r, cbuf_nxt;
  logic down_r, down_nxt;
  cnt_latch_e cl_r, cl_nxt;
  logic [15:0] mod_r, mod_nxt, mbuf_r, mbuf_nxt;
  mod_latch_e ml_r, ml_nxt;
  logic mpend_r, mpend_nxt;
  logic step_r, step_nxt;
  logic up_at_step_r, up_at_step_nxt;
  // channel
  logic ie_r, ie_nxt;
  logic [1:0] ms_r, ms_nxt, els_r, els_nxt;
  logic [15:0] cval_r, cval_nxt;
  logic pin_r, pin_nxt;
  // helpers
  logic take, wr_sc, wr_cnt, dbg, tick_ok, ovf_evt, at_top, wrap;
  logic [15:0] top, top_m1;
  logic [7:0] wb;
  logic rise, fall, match, extreme, ic_mode, oc_mode, epwm, chan_evt;
  flag_if ovf_f ();
  flag_if chf_f ();

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic reg_e decode(input logic [7:0] a);
    if (a == `OFS_TIMER_SC) decode = R_SC;
    else if (a == `OFS_COUNT_HI) decode = R_CNTH;
    else if (a == `OFS_COUNT_LO) decode = R_CNTL;
    else if (a == `OFS_MOD_HI) decode = R_MODH;
    else if (a == `OFS_MOD_LO) decode = R_MODL;
    else if (a == `OFS_CHAN_SC) decode = R_CSC;
    else if (a == `OFS_CHAN_VAL) decode = R_CVAL;
    else decode = R_NONE;
  endfunction : decode

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // read data is captured in the address phase, so data comes from a flop
  assign take = hsel && htrans[1] && hready;
  assign wb = hwdata[7:0];
  assign dbg = debug_halt_active;
  assign wr_sc = wr_r && (sel_r == R_SC);
  assign wr_cnt = wr_r && (sel_r == R_CNTH || sel_r == R_CNTL);

  always_comb begin
    wr_nxt = 1'b0;
    sel_nxt = R_NONE;
    rdata_nxt = rdata_r;
    if (take) begin
      wr_nxt = hwrite;
      sel_nxt = decode(haddr);
      if (!hwrite) begin
        rdata_nxt = 32'h0000_0000;
        case (decode(haddr))
          R_SC: rdata_nxt[7:0] = {overflow_flag, 1'b0, cpwm_r, clks_r, ps_r};
          R_CNTH: rdata_nxt[7:0] = (cl_r == CL_LO_READ && !dbg) ?
                                   cbuf_r[15:8] : cnt_r[15:8];
          R_CNTL: rdata_nxt[7:0] = (cl_r == CL_HI_READ && !dbg) ?
                                   cbuf_r[7:0] : cnt_r[7:0];
          R_MODH: rdata_nxt[7:0] = mod_r[15:8];
          R_MODL: rdata_nxt[7:0] = mod_r[7:0];
          R_CSC: rdata_nxt[7:0] = {chf_f.flag, ie_r, ms_r, els_r, 2'h0};
          R_CVAL: rdata_nxt[15:0] = cval_r;
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      sel_r <= R_NONE;
      rdata_r <= 32'h0000_0000;
    end else begin
      wr_r <= wr_nxt;
      sel_r <= sel_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  // ----------------------------------------------------------------
  // counter, read latch and modulo
  // ----------------------------------------------------------------
  // a modulo of zero means the full 16-bit range
  assign top = (mod_r == `MOD_RESET) ? `CNT_FULL : mod_r;
  assign top_m1 = top - 16'h0001;
  assign tick_ok = count_tick && (clks_r != `CLKS_OFF) && !dbg;
  assign at_top = (cnt_r >= top);
  assign wrap = tick_ok && !cpwm_r && at_top;
  // overflow held off while only one modulo byte has been written
  assign ovf_evt = tick_ok && at_top && !down_r && (ml_r == MW_IDLE);

  always_comb begin
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    cbuf_nxt = cbuf_r;
    cl_nxt = cl_r;
    mod_nxt = mod_r;
    mbuf_nxt = mbuf_r;
    ml_nxt = ml_r;
    mpend_nxt = mpend_r;
    step_nxt = 1'b0;
    up_at_step_nxt = up_at_step_r;
    // counting
    if (tick_ok) begin
      step_nxt = 1'b1;
      up_at_step_nxt = !down_r;
      if (!cpwm_r) begin
        cnt_nxt = at_top ? 16'h0000 : cnt_r + 16'h0001;
        down_nxt = 1'b0;
      end else if (!down_r) begin
        // up/down turnaround at the modulo and at zero
        down_nxt = at_top;
        cnt_nxt = at_top ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
      end else begin
        down_nxt = (cnt_r != 16'h0000);
        cnt_nxt = (cnt_r == 16'h0000) ? 16'h0001 : cnt_r - 16'h0001;
      end
      if (mpend_r && cnt_r == top_m1) begin
        mod_nxt = mbuf_r;
        mpend_nxt = 1'b0;
      end
    end
    // read latch; reads leave it alone while halted
    if (take && !hwrite && !dbg) begin
      if (decode(haddr) == R_CNTH) begin
        if (cl_r == CL_LO_READ) begin
          cl_nxt = CL_IDLE;
        end else begin
          cl_nxt = CL_HI_READ;
          cbuf_nxt = cnt_r;
        end
      end else if (decode(haddr) == R_CNTL) begin
        if (cl_r == CL_HI_READ) begin
          cl_nxt = CL_IDLE;
        end else begin
          cl_nxt = CL_LO_READ;
          cbuf_nxt = cnt_r;
        end
      end
    end
    // counter writes clear it whatever the data
    if (wr_cnt) begin
      cnt_nxt = 16'h0000;
      down_nxt = 1'b0;
    end
    if (wr_sc || wr_cnt) begin
      cl_nxt = CL_IDLE;
    end
    // modulo byte writes
    if (wr_r && (sel_r == R_MODH || sel_r == R_MODL)) begin
      if (dbg) begin
        // straight into the active value, latch left as it was
        if (sel_r == R_MODH) mod_nxt[15:8] = wb;
        else mod_nxt[7:0] = wb;
      end else begin
        if (sel_r == R_MODH) mbuf_nxt[15:8] = wb;
        else mbuf_nxt[7:0] = wb;
        if ((sel_r == R_MODH && ml_r == MW_LO_DONE) ||
            (sel_r == R_MODL && ml_r == MW_HI_DONE)) begin
          ml_nxt = MW_IDLE;
          if (clks_r == `CLKS_OFF) begin
            mod_nxt = (sel_r == R_MODH) ? {wb, mbuf_r[7:0]} :
                                           {mbuf_r[15:8], wb};
            mpend_nxt = 1'b0;
          end else begin
            mpend_nxt = 1'b1;
          end
        end else begin
          ml_nxt = (sel_r == R_MODH) ? MW_HI_DONE : MW_LO_DONE;
        end
      end
    end
    if (wr_sc) begin
      ml_nxt = MW_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 16'h0000;
      down_r <= 1'b0;
      cbuf_r <= 16'h0000;
      cl_r <= CL_IDLE;
      mod_r <= `MOD_RESET;
      mbuf_r <= `MOD_RESET;
      ml_r <= MW_IDLE;
      mpend_r <= 1'b0;
      step_r <= 1'b0;
      up_at_step_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      down_r <= down_nxt;
      cbuf_r <= cbuf_nxt;
      cl_r <= cl_nxt;
      mod_r <= mod_nxt;
      mbuf_r <= mbuf_nxt;
      ml_r <= ml_nxt;
      mpend_r <= mpend_nxt;
      step_r <= step_nxt;
      up_at_step_r <= up_at_step_nxt;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_comb begin
    cpwm_nxt = cpwm_r;
    clks_nxt = clks_r;
    ps_nxt = ps_r;
    ie_nxt = ie_r;
    ms_nxt = ms_r;
    els_nxt = els_r;
    cval_nxt = cval_r;
    if (wr_sc) begin
      cpwm_nxt = wb[`SC_CPWM_BIT];
      clks_nxt = wb[`SC_CLKS_HI:`SC_CLKS_LO];
      ps_nxt = wb[`SC_PS_HI:0];
    end
    if (wr_r && sel_r == R_CSC) begin
      ie_nxt = wb[`CSC_IE_BIT];
      ms_nxt = {wb[`CSC_MSU_BIT], wb[`CSC_MSL_BIT]};
      els_nxt = {wb[`CSC_ELU_BIT], wb[`CSC_ELL_BIT]};
    end
    if (wr_r && sel_r == R_CVAL) begin
      cval_nxt = hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpwm_r <= 1'b0;
      clks_r <= `CLKS_OFF;
      ps_r <= 3'h0;
      ie_r <= 1'b0;
      ms_r <= 2'h0;
      els_r <= 2'h0;
      cval_r <= 16'h0000;
    end else begin
      cpwm_r <= cpwm_nxt;
      clks_r <= clks_nxt;
      ps_r <= ps_nxt;
      ie_r <= ie_nxt;
      ms_r <= ms_nxt;
      els_r <= els_nxt;
      cval_r <= cval_nxt;
    end
  end

  // ----------------------------------------------------------------
  // overflow and channel flags
  // ----------------------------------------------------------------
  assign ovf_f.set_evt = ovf_evt;
  assign ovf_f.rd_arm = take && !hwrite && decode(haddr) == R_SC;
  assign ovf_f.wr_zero = wr_sc && !wb[`SC_OVF_BIT];
  event_flag u_ovf (.hclk(hclk), .hresetn(hresetn), .f(ovf_f));

  // mode decode of the single channel
  assign ic_mode = !cpwm_r && ms_r == 2'h0;
  assign oc_mode = !cpwm_r && ms_r == 2'h1;
  assign epwm = !cpwm_r && ms_r[1];
  // match one cycle after the counter moved, on the new count
  assign match = step_r && (cnt_r == cval_r);
  // 0% and 100% duty: value zero or above the modulo
  assign extreme = (cval_r == 16'h0000) || (mod_r != `MOD_RESET &&
                   cval_r > mod_r);
  always_comb begin
    chan_evt = 1'b0;
    if (els_r != 2'h0) begin
      if (ic_mode) begin
        chan_evt = (els_r[0] && rise) || (els_r[1] && fall);
      end else if (oc_mode) begin
        chan_evt = match;
      end else begin
        chan_evt = match && !extreme;
      end
    end
  end

  // edge detector needs the pin steady before capture is armed
  pin_edge u_pin (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(chan_pin_in),
    .rise(rise),
    .fall(fall)
  );

  assign chf_f.set_evt = chan_evt;
  assign chf_f.rd_arm = take && !hwrite && decode(haddr) == R_CSC;
  assign chf_f.wr_zero = wr_r && sel_r == R_CSC && !wb[`CSC_FLAG_BIT];
  event_flag u_chf (.hclk(hclk), .hresetn(hresetn), .f(chf_f));

  // ----------------------------------------------------------------
  // channel pin
  // ----------------------------------------------------------------
  // low-true when the lower edge/level bit is set
  always_comb begin
    pin_nxt = pin_r;
    if (oc_mode && match) begin
      case (els_r)
        2'h1: pin_nxt = !pin_r;
        2'h2: pin_nxt = 1'b0;
        2'h3: pin_nxt = 1'b1;
        default: pin_nxt = pin_r;
      endcase
    end else if (epwm) begin
      if (wrap) pin_nxt = els_r[0] ? 1'b0 : 1'b1;
      if (match) pin_nxt = els_r[0];
    end else if (cpwm_r && match) begin
      pin_nxt = up_at_step_r ? els_r[0] : !els_r[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign chan_pin_out = pin_r;
  assign chan_pin_oe = (els_r != 2'h0) && !ic_mode;
  assign chan_irq = chf_f.flag && ie_r;
  assign clock_source_select = clks_r;
  assign prescale_select = ps_r;
  assign center_aligned_select = cpwm_r;
  assign count_value = cnt_r;
  assign overflow_flag = ovf_f.flag;
endmodule : tmr_ctrl
`default_nettype wire

//--- dv/tmr_ctrl_chk.sv
// Purpose: port-level checks of the timer block
// Assumes: one clock, hresetn asynchronous and active low
// Notes: channel controls are mirrored from bus writes
`timescale 1ns/1ns
`default_nettype none
`include "tmr_cfg.svh"
module tmr_ctrl_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus side
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // timer side
  input wire logic count_tick,
  input wire logic debug_halt_active,
  input wire logic [1:0] clock_source_select,
  input wire logic center_aligned_select,
  input wire logic [15:0] count_value,
  input wire logic chan_pin_oe,
  input wire logic chan_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // channel control mirror
  // ----------------------------------------
  logic wr_r;
  logic [7:0] csc_r;
  logic cap;
  // byte lands at the edge that closes the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      csc_r <= 8'h00;
    end else if (hready) begin
      wr_r <= hsel && htrans[1] && hwrite && haddr == `OFS_CHAN_SC;
      if (wr_r) csc_r <= hwdata[7:0];
    end
  end
  assign cap = !center_aligned_select && csc_r[5:4] == 2'b00;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // a counter clear reads zero, so zero is left out of the hold checks
  AST_FREEZE: assert property (
    $past(debug_halt_active) && count_value != 16'h0000
    |-> $stable(count_value)) else $error("count moved in debug halt");
  AST_CLK_OFF: assert property (
    $past(clock_source_select) == `CLKS_OFF && count_value != 16'h0000
    |-> $stable(count_value)) else $error("count moved with clock off");
  AST_TICK_ONLY: assert property (
    !$past(count_tick) && count_value != 16'h0000
    |-> $stable(count_value)) else $error("count moved without tick");
  AST_STEP: assert property (
    $past(count_tick) && $past(clock_source_select) != 2'h0 &&
    !$past(debug_halt_active) && !$past(center_aligned_select)
    |-> count_value == $past(count_value) + 16'h0001 ||
    count_value == 16'h0000) else $error("up count step wrong");
  AST_PIN_FREE: assert property (
    csc_r[3:2] == 2'b00 || cap |-> !chan_pin_oe)
    else $error("pin driven while released");
  AST_PIN_DRIVE: assert property (
    csc_r[3:2] != 2'b00 && !cap |-> chan_pin_oe)
    else $error("pin not driven");
  AST_IRQ_GATE: assert property (
    !csc_r[6] |-> !chan_irq) else $error("request with enable off");
  AST_IRQ_FALL: assert property (
    $fell(chan_irq) |-> $past(wr_r)) else $error("request fell alone");
endmodule : tmr_ctrl_chk
bind tmr_ctrl tmr_ctrl_chk i_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .count_tick, .debug_halt_active, .clock_source_select,
  .center_aligned_select, .count_value, .chan_pin_oe, .chan_irq
);
`default_nettype wire

//--- dv/timer_modulo_and_channel_ctrl_tb.sv
// Purpose: self-checking bench of the timer block over AHB-Lite
// Assumes: zero wait states, hready looped back from hreadyout
// Notes: inputs move 1 ns after the edge so outputs have settled
`timescale 1ns/1ns
`default_nettype none
`include "tmr_cfg.svh"
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
  end \
end
module timer_modulo_and_channel_ctrl_tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pin_drv;
  logic count_tick, debug_halt_active, center_aligned_select;
  logic overflow_flag, chan_pin_in, chan_pin_out, chan_pin_oe, chan_irq;
  logic [1:0] htrans, clock_source_select;
  logic [2:0] hsize, prescale_select;
  logic [7:0] haddr;
  logic [15:0] count_value;
  logic [31:0] hwdata, hrdata, rdv;
  int mismatches = 0;
  int total_checks = 0;
  // one slave, so its ready is the bus ready; pin resolved from enable
  assign hready = hreadyout;
  assign chan_pin_in = chan_pin_oe ? chan_pin_out : pin_drv;
  tmr_ctrl i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .count_tick, .debug_halt_active,
    .clock_source_select, .prescale_select, .center_aligned_select,
    .count_value, .overflow_flag, .chan_pin_in, .chan_pin_out, .chan_pin_oe,
    .chan_irq
  );
  // ----------------------------------------
  // bus and tick drivers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge hclk);
      #1;
    end
  endtask : cyc
  // bounded wait for ready sampled high at an edge
  task automatic rdy();
    int n;
    n = 0;
    cyc(1);
    while (hready !== 1'b1 && n < 16) begin
      cyc(1);
      n++;
    end
    if (n == 16) begin
      mismatches++;
      test_done();
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    rdv = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // ticks two cycles apart, then two cycles for flags and pin to land
  task automatic tick(input int n);
    repeat (n) begin
      count_tick <= 1'b1;
      cyc(1);
      count_tick <= 1'b0;
      cyc(1);
    end
    cyc(2);
  endtask : tick
  task automatic clr_ovf();
    rd(`OFS_TIMER_SC);
    wr(`OFS_TIMER_SC, 32'h08);
  endtask : clr_ovf
  task automatic clr_flag(input logic [7:0] v);
    rd(`OFS_CHAN_SC);
    wr(`OFS_CHAN_SC, {24'h0, v});
  endtask : clr_flag
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] ra [5] = '{`OFS_TIMER_SC, `OFS_MOD_HI, `OFS_MOD_LO,
                           `OFS_CHAN_SC, 8'h1C};
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK({hresp, rdv}, 33'h0)
    end
    tick(3);
    `CHK(count_value, 16'h0)
  endtask : t_reset
  // modulo 4 active at once, then a smaller value that must wait
  task automatic t_modulo();
    wr(`OFS_COUNT_LO, 32'h0);
    wr(`OFS_MOD_HI, 32'h0);
    wr(`OFS_MOD_LO, 32'h4);
    wr(`OFS_TIMER_SC, 32'h08);
    `CHK({center_aligned_select, clock_source_select, prescale_select}, 6'h08)
    tick(4);
    `CHK(overflow_flag, 1'b0)
    tick(1);
    `CHK({overflow_flag, count_value}, 17'h10000)
    tick(1);
    wr(`OFS_MOD_HI, 32'h0);
    wr(`OFS_MOD_LO, 32'h3);
    tick(3);
    `CHK(count_value, 16'h4)
    wr(`OFS_COUNT_LO, 32'h0);
    clr_ovf();
    wr(`OFS_MOD_HI, 32'h0);
    tick(4);
    `CHK({overflow_flag, count_value}, 17'h0)
    wr(`OFS_MOD_LO, 32'h3);
    tick(4);
    `CHK({overflow_flag, count_value}, 17'h10000)
    wr(`OFS_MOD_HI, 32'h0);
    clr_ovf();
    tick(4);
    `CHK({overflow_flag, count_value}, 17'h10000)
  endtask : t_modulo
  task automatic t_debug();
    tick(2);
    debug_halt_active <= 1'b1;
    tick(3);
    `CHK(count_value, 16'h2)
    wr(`OFS_MOD_LO, 32'h5);
    debug_halt_active <= 1'b0;
    clr_ovf();
    tick(3);
    `CHK({overflow_flag, count_value}, 17'h5)
    tick(1);
    `CHK({overflow_flag, count_value}, 17'h10000)
  endtask : t_debug
  // match at 2 in a period of six ticks
  task automatic t_compare();
    logic [7:0] sc [3] = '{8'h14, 8'h1C, 8'h18};
    logic pe [3] = '{1'b0, 1'b1, 1'b0};
    wr(`OFS_CHAN_VAL, 32'h2);
    wr(`OFS_CHAN_SC, 32'h5C);
    tick(2);
    `CHK({chan_irq, chan_pin_out}, 2'b11)
    wr(`OFS_CHAN_SC, 32'h5C);
    `CHK(chan_irq, 1'b1)
    rd(`OFS_CHAN_SC);
    `CHK(rdv, 32'hDC)
    tick(6);
    wr(`OFS_CHAN_SC, 32'h5C);
    `CHK(chan_irq, 1'b1)
    clr_flag(8'h5C);
    `CHK(chan_irq, 1'b0)
    wr(`OFS_CHAN_SC, 32'hDC);
    `CHK(chan_irq, 1'b0)
    foreach (sc[i]) begin
      wr(`OFS_CHAN_SC, {24'h0, sc[i]});
      tick(6);
      `CHK({chan_irq, chan_pin_out}, {1'b0, pe[i]})
    end
    clr_flag(8'h10);
    `CHK(chan_pin_oe, 1'b0)
  endtask : t_compare
  task automatic t_pwm();
    logic [15:0] cv [3] = '{16'h0, 16'h6, 16'h2};
    logic fe [3] = '{1'b0, 1'b0, 1'b1};
    wr(`OFS_COUNT_LO, 32'h0);
    wr(`OFS_CHAN_SC, 32'h68);
    foreach (cv[i]) begin
      wr(`OFS_CHAN_VAL, {16'h0, cv[i]});
      tick(12);
      `CHK(chan_irq, fe[i])
      clr_flag(8'h68);
    end
    `CHK(chan_pin_out, 1'b1)
    tick(3);
    `CHK(chan_pin_out, 1'b0)
  endtask : t_pwm
  // pin held low well before each switch into capture
  task automatic t_capture();
    logic [7:0] sc [3] = '{8'h44, 8'h48, 8'h4C};
    logic er [3] = '{1'b1, 1'b0, 1'b1};
    logic ef [3] = '{1'b0, 1'b1, 1'b1};
    wr(`OFS_TIMER_SC, 32'h0);
    tick(2);
    `CHK(count_value, 16'h3)
    foreach (sc[i]) begin
      wr(`OFS_CHAN_SC, {24'h0, sc[i]});
      pin_drv <= 1'b1;
      cyc(6);
      `CHK(chan_irq, er[i])
      clr_flag(sc[i]);
      pin_drv <= 1'b0;
      cyc(6);
      `CHK(chan_irq, ef[i])
      clr_flag(sc[i]);
    end
  endtask : t_capture
  // center-aligned: up to 5 then down; X1 sets on up match, clears on down
  task automatic t_center();
    wr(`OFS_COUNT_LO, 32'h0);
    wr(`OFS_CHAN_SC, 32'h04);
    wr(`OFS_TIMER_SC, 32'h28);
    `CHK({center_aligned_select, chan_pin_oe}, 2'b11)
    tick(2);
    `CHK({chan_pin_out, count_value}, 17'h10002)
    tick(6);
    `CHK({chan_pin_out, count_value}, 17'h00002)
  endtask : t_center
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // the whole run needs a few hundred cycles
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'h2;
    haddr = 8'h00;
    hwdata = 32'h0;
    count_tick = 1'b0;
    debug_halt_active = 1'b0;
    pin_drv = 1'b0;
    cyc(6);
    hresetn <= 1'b1;
    cyc(1);
    t_reset();
    t_modulo();
    t_debug();
    t_compare();
    t_pwm();
    t_capture();
    t_center();
    test_done();
  end
endmodule : timer_modulo_and_channel_ctrl_tb
`default_nettype wire
